/* src/crt_pkg.sv */
/*
  Constants shared by the reset sequencer of the serial-network center device
  and its communication-time calculator: register indices, reset values,
  memory window, clear lengths and the time coefficients of the network.
  Assumes a 16-bit register port with 9-bit word addresses.
*/
package crt_pkg;

  localparam int ADDR_W = 9;
  localparam int DATA_W = 16;

  // Register indices (word addresses)
  localparam logic [8:0] OFS_COMMAND = 9'h000;
  localparam logic [8:0] OFS_STATUS = 9'h001;
  localparam logic [8:0] OFS_IRQ_STATUS = 9'h002;
  localparam logic [8:0] OFS_IO_BUFFER = 9'h003;
  localparam logic [8:0] OFS_REVISION = 9'h004;
  localparam logic [8:0] OFS_TIME_CFG = 9'h005;
  localparam logic [8:0] OFS_DEV_COUNT = 9'h006;
  localparam logic [8:0] OFS_SEND_BYTES = 9'h007;
  localparam logic [8:0] OFS_REPLY_BYTES = 9'h008;
  localparam logic [8:0] OFS_EXCH_COUNT = 9'h009;
  localparam logic [8:0] OFS_CT_TIME = 9'h00A;
  localparam logic [8:0] OFS_SEND_TIME = 9'h00B;
  localparam logic [8:0] OFS_REPLY_TIME = 9'h00C;
  localparam logic [8:0] OFS_EXCH_TIME = 9'h00D;
  localparam logic [8:0] OFS_TOTAL_LO = 9'h00E;
  localparam logic [8:0] OFS_TOTAL_HI = 9'h00F;
  localparam logic [8:0] OFS_TX_DATA = 9'h010;
  localparam logic [8:0] OFS_RX_DATA = 9'h011;
  localparam logic [8:0] OFS_FIFO_LEVEL = 9'h012;

  // Field positions
  localparam int STAT_BUSY_BIT = 13;
  localparam int CFG_SPEED_LSB = 0;
  localparam int CFG_REPLY_DATA_BIT = 2;

  // Reset values
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [7:0] MEM_RESET = 8'h00;
  // Arbitrary identification value
  localparam logic [15:0] REVISION_CODE = 16'h00A5;

  // Shared memory window, cleared after reset
  localparam logic [8:0] MEM_LO = 9'h078;
  localparam logic [8:0] MEM_HI = 9'h1FF;
  localparam int MEM_WORDS = 392;

  // Least clear length in system clock periods per clock mode
  localparam logic [9:0] CLR_CYC_LO = 10'd270;
  localparam logic [9:0] CLR_CYC_HI = 10'd540;

  // Transmit FIFO
  localparam int FIFO_DEPTH = 8;

  // Network times, printed figures in hundredths of a microsecond
  localparam int UNIT_X100 = 5;
  localparam int CT_X100 = 770;
  localparam int GAP_X100 = 740;
  localparam int BYTE_X100 = 60;
  localparam int SEND_X100 = 325;
  localparam int RDATA_X100 = 565;
  localparam int RNODATA_X100 = 505;
  // Same times as counts of 50 ns units
  localparam logic [15:0] CT_U = 16'(CT_X100 / UNIT_X100);
  localparam logic [15:0] GAP_U = 16'(GAP_X100 / UNIT_X100);
  localparam logic [15:0] BYTE_U = 16'(BYTE_X100 / UNIT_X100);
  localparam logic [15:0] SEND_U = 16'(SEND_X100 / UNIT_X100);
  localparam logic [15:0] RDATA_U = 16'(RDATA_X100 / UNIT_X100);
  localparam logic [15:0] RNODATA_U = 16'(RNODATA_X100 / UNIT_X100);

  typedef enum logic [2:0] {
    CRT_ST_RESET = 3'b001,
    CRT_ST_CLEAR = 3'b010,
    CRT_ST_READY = 3'b100
  } crt_state_t;

endpackage : crt_pkg

/* src/crt_time.sv */
/*
  Communication-time calculator: per-device cycle time, data send time,
  reply time, exchange time and total cycle time, in 50 ns units.
  Assumes its inputs are stable registers of the same clock domain.
*/
`timescale 1ns/1ps
`default_nettype none

module crt_time (
  input wire logic [1:0] speed,
  input wire logic reply_data,
  input wire logic [6:0] dev_count,
  input wire logic [7:0] send_bytes,
  input wire logic [7:0] reply_bytes,
  input wire logic [7:0] exch_count,
  output logic [15:0] per_device_cycle_time,
  output logic [15:0] data_send_time,
  output logic [15:0] reply_time,
  output logic [15:0] exch_time,
  output logic [31:0] total_time
);

  logic [31:0] ct_w;
  logic [31:0] st_w;
  logic [31:0] jt_w;
  logic [31:0] xt_w;
  logic [31:0] cyc_w;

  always_comb begin
    // Coefficient 1, 2, 4, 8 for 20, 10, 5, 2.5 Mbps is a left shift
    ct_w = 32'(crt_pkg::CT_U) << speed; // see [R11]
    cyc_w = (ct_w + 32'(crt_pkg::GAP_U)) * 32'(dev_count); // see [R12]
    st_w = (32'(send_bytes) * 32'(crt_pkg::BYTE_U) + 32'(crt_pkg::SEND_U)) << speed; // see [R13]
    if (reply_data) begin
      jt_w = (32'(reply_bytes) * 32'(crt_pkg::BYTE_U) + 32'(crt_pkg::RDATA_U)) << speed; // see [R14]
    end else begin
      jt_w = 32'(crt_pkg::RNODATA_U) << speed; // see [R14]
    end
    xt_w = st_w + jt_w + 32'(crt_pkg::GAP_U); // see [R15]
  end

  // Widest case (255 bytes both ways at 2.5 Mbps) still fits 16 bits
  assign per_device_cycle_time = ct_w[15:0];
  assign data_send_time = st_w[15:0];
  assign reply_time = jt_w[15:0];
  assign exch_time = xt_w[15:0];
  assign total_time = cyc_w + xt_w * 32'(exch_count); // see [R15]

endmodule : crt_time

`default_nettype wire

/* src/crt_seq.sv */
/*
  Reset and initialisation sequencer of the serial-network center device,
  with its register port, shared memory window, transmit FIFO and the
  communication-time calculator.
  Assumes a host on clk_sys that strobes reads and writes for one cycle and
  holds reset_n low at least 10 clocks with the clock running.
*/
//
// Contract
// [R1] The host holds reset low for at least 10 system clock periods.
// [R2] The system clock keeps running for the whole time reset is held.
// [R3] After reset the device writes zero to every word 078h..1FFh, then becomes ready.
// [R4] The reset-busy flag, status bit 13, stays 1 for the whole memory clear.
// [R5] The host polls status and does not access the device until reset-busy is 0.
// [R6] The clear lasts at least 270 clocks with clock-select low, 540 with it high.
// [R7] After reset every register reads 0000h except the revision register; CT, send, reply and exchange times read 154, 65, 101 and 314 here.
// [R8] Transmit and receive FIFO contents are undefined after reset.
// [R9] Device information and cyclic error flags are cleared to 00h after reset.
// [R10] Input-change enables, input-change flags and port data are cleared to 00h.
// [R11] Speed coefficient is 1, 2, 4, 8 at 20, 10, 5, 2.5 Mbps.
// [R12] Cycle time is (7.7 us times coefficient plus 7.4 us) times the device count.
// [R13] Send time of B bytes is (B times 0.6 plus 3.25) us times the coefficient.
// [R14] Reply time is (B times 0.6 plus 5.65) us, or 5.05 us without data, times the coefficient.
// [R15] An exchange takes send plus reply plus 7.4 us and adds to the cycle time.
// [R16] The clock is near 40 MHz with clock-select low, up to 80 MHz with it high.
// [R17] A clear counter whose terminal count follows clock-select sets the clear length; with clock-select low the 392-word walk sets it here.
`timescale 1ns/1ps
`default_nettype none

module crt_seq (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clock_select,
  input wire logic [8:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic reset_busy_flag
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    crt_pkg::crt_state_t state;
    logic [1:0] sel_sync;
    logic sel_hi;
    logic [9:0] clr_cnt;
    logic [8:0] clr_addr;
    logic clr_addr_done;
    logic busy;
    logic [15:0] command;
    logic [15:0] irq_status;
    logic [15:0] io_buf;
    logic [1:0] speed;
    logic reply_data;
    logic [6:0] dev_count;
    logic [7:0] send_bytes;
    logic [7:0] reply_bytes;
    logic [7:0] exch_count;
    logic [15:0] ct_time;
    logic [15:0] st_time;
    logic [15:0] jt_time;
    logic [15:0] xt_time;
    logic [31:0] total_time;
    logic [2:0] wr_ptr;
    logic [2:0] rd_ptr;
    logic [3:0] level;
    logic [15:0] rdata;
  } crt_regs_t;

  crt_regs_t st_r;
  crt_regs_t st_nxt;

  // Shared memory: device info, error flags, change enables/flags, port data
  logic [15:0] mem [0:crt_pkg::MEM_WORDS-1];
  // Transmit FIFO storage; deliberately never reset
  logic [15:0] fifo [0:crt_pkg::FIFO_DEPTH-1];

  logic mem_we;
  logic [8:0] mem_waddr;
  logic [15:0] mem_wdata;
  logic fifo_we;
  logic [15:0] ct_w;
  logic [15:0] st_w;
  logic [15:0] jt_w;
  logic [15:0] xt_w;
  logic [31:0] total_w;
  logic [9:0] clr_term;
  logic host_ok;

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  function automatic logic in_mem(input logic [8:0] a);
    in_mem = (a >= crt_pkg::MEM_LO) && (a <= crt_pkg::MEM_HI);
  endfunction : in_mem

  function automatic logic [8:0] mem_index(input logic [8:0] a);
    mem_index = a - crt_pkg::MEM_LO;
  endfunction : mem_index

  ////////////////////////////////////////////////////////////////////////////
  // Time calculator

  crt_time u_time (
    .speed(st_r.speed),
    .reply_data(st_r.reply_data),
    .dev_count(st_r.dev_count),
    .send_bytes(st_r.send_bytes),
    .reply_bytes(st_r.reply_bytes),
    .exch_count(st_r.exch_count),
    .per_device_cycle_time(ct_w),
    .data_send_time(st_w),
    .reply_time(jt_w),
    .exch_time(xt_w),
    .total_time(total_w)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    st_nxt = st_r;
    mem_we = 1'b0;
    mem_waddr = 9'h000;
    mem_wdata = 16'h0000;
    fifo_we = 1'b0;

    // Two-flop synchroniser for the clock-select pin
    st_nxt.sel_sync = {st_r.sel_sync[0], clock_select};

    // Clear length follows the mode caught at reset release
    clr_term = st_r.sel_hi ? crt_pkg::CLR_CYC_HI : crt_pkg::CLR_CYC_LO; // see [R17]
    // Host writes, memory reads and FIFO pops are honoured only once the clear is over
    host_ok = (st_r.state == crt_pkg::CRT_ST_READY);

    // Time results are registered so reads see a stable word
    st_nxt.ct_time = ct_w; // see [R12]
    st_nxt.st_time = st_w; // see [R13]
    st_nxt.jt_time = jt_w; // see [R14]
    st_nxt.xt_time = xt_w; // see [R15]
    st_nxt.total_time = total_w; // see [R15]

    case (st_r.state)
      crt_pkg::CRT_ST_RESET: begin
        st_nxt.state = crt_pkg::CRT_ST_CLEAR;
      end
      crt_pkg::CRT_ST_CLEAR: begin
        // One word per clock; counter runs on to the mode's least length
        if (!st_r.clr_addr_done) begin
          mem_we = 1'b1; // see [R3]
          mem_waddr = mem_index(st_r.clr_addr);
          mem_wdata = {crt_pkg::MEM_RESET, crt_pkg::MEM_RESET}; // see [R9] see [R10]
          if (st_r.clr_addr == crt_pkg::MEM_HI) begin
            st_nxt.clr_addr_done = 1'b1;
          end else begin
            st_nxt.clr_addr = st_r.clr_addr + 9'h001;
          end
        end
        if (st_r.clr_cnt != clr_term) begin
          st_nxt.clr_cnt = st_r.clr_cnt + 10'h001; // see [R6]
        end
        if (st_r.clr_addr_done && (st_r.clr_cnt >= clr_term - 10'h001)) begin
          st_nxt.state = crt_pkg::CRT_ST_READY; // see [R3] see [R6]
          st_nxt.busy = 1'b0; // see [R4]
        end
      end
      crt_pkg::CRT_ST_READY: begin
        st_nxt.state = crt_pkg::CRT_ST_READY;
      end
      default: begin
        st_nxt.state = crt_pkg::CRT_ST_RESET;
      end
    endcase

    //////////////////////////////////////////////////////////////////////////
    // Register writes

    if (reg_wr && host_ok) begin
      if (in_mem(reg_addr)) begin
        mem_we = 1'b1;
        mem_waddr = mem_index(reg_addr);
        mem_wdata = reg_wdata;
      end else begin
        case (reg_addr)
          crt_pkg::OFS_COMMAND: begin
            st_nxt.command = reg_wdata;
          end
          crt_pkg::OFS_IO_BUFFER: begin
            st_nxt.io_buf = reg_wdata;
          end
          crt_pkg::OFS_TIME_CFG: begin
            st_nxt.speed = reg_wdata[crt_pkg::CFG_SPEED_LSB +: 2]; // see [R11]
            st_nxt.reply_data = reg_wdata[crt_pkg::CFG_REPLY_DATA_BIT];
          end
          crt_pkg::OFS_DEV_COUNT: begin
            st_nxt.dev_count = reg_wdata[6:0];
          end
          crt_pkg::OFS_SEND_BYTES: begin
            st_nxt.send_bytes = reg_wdata[7:0];
          end
          crt_pkg::OFS_REPLY_BYTES: begin
            st_nxt.reply_bytes = reg_wdata[7:0];
          end
          crt_pkg::OFS_EXCH_COUNT: begin
            st_nxt.exch_count = reg_wdata[7:0];
          end
          crt_pkg::OFS_TX_DATA: begin
            // A push into a full FIFO is dropped
            if (st_r.level != 4'(crt_pkg::FIFO_DEPTH)) begin
              fifo_we = 1'b1;
              st_nxt.wr_ptr = st_r.wr_ptr + 3'h1;
            end
          end
          default: begin
            st_nxt.command = st_r.command;
          end
        endcase
      end
    end

    //////////////////////////////////////////////////////////////////////////
    // Register reads, answered in the next cycle only

    st_nxt.rdata = 16'h0000;
    if (reg_rd) begin
      if (in_mem(reg_addr)) begin
        // Memory reads during the clear give zero, not half-cleared data
        st_nxt.rdata = host_ok ? mem[mem_index(reg_addr)] : 16'h0000;
      end else begin
        case (reg_addr)
          crt_pkg::OFS_COMMAND: begin
            st_nxt.rdata = st_r.command;
          end
          crt_pkg::OFS_STATUS: begin
            st_nxt.rdata[crt_pkg::STAT_BUSY_BIT] = st_r.busy; // see [R4]
          end
          crt_pkg::OFS_IRQ_STATUS: begin
            st_nxt.rdata = st_r.irq_status;
          end
          crt_pkg::OFS_IO_BUFFER: begin
            st_nxt.rdata = st_r.io_buf;
          end
          crt_pkg::OFS_REVISION: begin
            st_nxt.rdata = crt_pkg::REVISION_CODE; // see [R7]
          end
          crt_pkg::OFS_TIME_CFG: begin
            st_nxt.rdata[crt_pkg::CFG_SPEED_LSB +: 2] = st_r.speed;
            st_nxt.rdata[crt_pkg::CFG_REPLY_DATA_BIT] = st_r.reply_data;
          end
          crt_pkg::OFS_DEV_COUNT: begin
            st_nxt.rdata = {9'h000, st_r.dev_count};
          end
          crt_pkg::OFS_SEND_BYTES: begin
            st_nxt.rdata = {8'h00, st_r.send_bytes};
          end
          crt_pkg::OFS_REPLY_BYTES: begin
            st_nxt.rdata = {8'h00, st_r.reply_bytes};
          end
          crt_pkg::OFS_EXCH_COUNT: begin
            st_nxt.rdata = {8'h00, st_r.exch_count};
          end
          crt_pkg::OFS_CT_TIME: begin
            st_nxt.rdata = st_r.ct_time;
          end
          crt_pkg::OFS_SEND_TIME: begin
            st_nxt.rdata = st_r.st_time;
          end
          crt_pkg::OFS_REPLY_TIME: begin
            st_nxt.rdata = st_r.jt_time;
          end
          crt_pkg::OFS_EXCH_TIME: begin
            st_nxt.rdata = st_r.xt_time;
          end
          crt_pkg::OFS_TOTAL_LO: begin
            st_nxt.rdata = st_r.total_time[15:0];
          end
          crt_pkg::OFS_TOTAL_HI: begin
            st_nxt.rdata = st_r.total_time[31:16];
          end
          crt_pkg::OFS_RX_DATA: begin
            // Looped-back head of the FIFO; an empty pop reads whatever is stored
            if (host_ok) begin
              st_nxt.rdata = fifo[st_r.rd_ptr]; // see [R8]
              if (st_r.level != 4'h0) begin
                st_nxt.rd_ptr = st_r.rd_ptr + 3'h1;
              end
            end
          end
          crt_pkg::OFS_FIFO_LEVEL: begin
            st_nxt.rdata = {12'h000, st_r.level};
          end
          default: begin
            st_nxt.rdata = 16'h0000;
          end
        endcase
      end
    end

    // Level follows the pointers; push and pop can meet in one cycle only
    // through back-to-back strobes, never both at once
    st_nxt.level = 4'(st_nxt.wr_ptr - st_nxt.rd_ptr);
    if ((st_nxt.wr_ptr == st_nxt.rd_ptr) && fifo_we) begin
      st_nxt.level = 4'(crt_pkg::FIFO_DEPTH);
    end else if ((st_nxt.wr_ptr == st_nxt.rd_ptr) && (st_r.level == 4'(crt_pkg::FIFO_DEPTH))
                 && !(reg_rd && (reg_addr == crt_pkg::OFS_RX_DATA))) begin
      st_nxt.level = st_r.level;
    end

    //////////////////////////////////////////////////////////////////////////
    // Synchronous reset

    if (!reset_n) begin
      st_nxt.state = crt_pkg::CRT_ST_RESET;
      // The mode is sampled each reset clock; a 10-clock reset leaves it settled
      st_nxt.sel_hi = st_r.sel_sync[1]; // see [R1] see [R16]
      st_nxt.clr_cnt = 10'h000;
      st_nxt.clr_addr = crt_pkg::MEM_LO;
      st_nxt.clr_addr_done = 1'b0;
      st_nxt.busy = 1'b1; // see [R4]
      st_nxt.command = crt_pkg::REG_RESET; // see [R7]
      st_nxt.irq_status = crt_pkg::REG_RESET; // see [R7]
      st_nxt.io_buf = crt_pkg::REG_RESET; // see [R7]
      st_nxt.speed = 2'h0;
      st_nxt.reply_data = 1'b0;
      st_nxt.dev_count = 7'h00;
      st_nxt.send_bytes = 8'h00;
      st_nxt.reply_bytes = 8'h00;
      st_nxt.exch_count = 8'h00;
      st_nxt.ct_time = crt_pkg::REG_RESET;
      st_nxt.st_time = crt_pkg::REG_RESET;
      st_nxt.jt_time = crt_pkg::REG_RESET;
      st_nxt.xt_time = crt_pkg::REG_RESET;
      st_nxt.total_time = 32'h0000_0000;
      st_nxt.wr_ptr = 3'h0; // see [R8]
      st_nxt.rd_ptr = 3'h0;
      st_nxt.level = 4'h0;
      st_nxt.rdata = crt_pkg::REG_RESET;
      mem_we = 1'b0;
      fifo_we = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clk_sys) begin
    st_r <= st_nxt;
  end

  // Memory is cleared by the walk, not by reset, to keep it a plain RAM
  always_ff @(posedge clk_sys) begin
    if (mem_we) begin
      mem[mem_waddr] <= mem_wdata; // see [R3]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (fifo_we) begin
      fifo[st_r.wr_ptr] <= reg_wdata;
    end
  end

  assign reg_rdata = st_r.rdata;
  assign reset_busy_flag = st_r.busy; // see [R4]

endmodule : crt_seq

`default_nettype wire

/* verification/crt_seq_sva.sv */
/* Port checker of the reset sequencer: busy flag, clear length and read answers.
   Assumes clock_select stays steady through each reset and clear. */
`timescale 1ns/1ps
`default_nettype none
module crt_seq_sva (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clock_select,
  input wire logic [8:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic reset_busy_flag
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  logic [9:0] busy_cnt_r;
  ////////////////////////////////////////////////////////////////////////////////
  // Busy cycles since release; saturates so a stuck flag cannot wrap to a legal count
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      busy_cnt_r <= 10'h000;
    end else if (reset_busy_flag && busy_cnt_r != 10'h3FF) begin
      busy_cnt_r <= busy_cnt_r + 10'h001;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  busy_in_reset_a: assert property (disable iff (1'b0) !reset_n |=> reset_busy_flag)
    else $error("busy flag low during reset");
  rdata_in_reset_a: assert property (disable iff (1'b0) !reset_n |=> reg_rdata == 16'h0000)
    else $error("read data not zero during reset");
  clear_length_a: assert property ($fell(reset_busy_flag) |-> busy_cnt_r >= (clock_select ? 10'h21C : 10'h10E))
    else $error("memory clear shorter than its minimum");
  clear_ends_a: assert property (reset_busy_flag |-> busy_cnt_r <= 10'h258)
    else $error("device never becomes ready");
  busy_stays_low_a: assert property (!reset_busy_flag |=> !reset_busy_flag)
    else $error("busy flag rose without reset");
  read_idle_zero_a: assert property (!reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data outside its answer cycle");
  revision_read_a: assert property (reg_rd && reg_addr == crt_pkg::OFS_REVISION |=> reg_rdata == crt_pkg::REVISION_CODE)
    else $error("revision register wrong");
  status_ready_a: assert property (reg_rd && reg_addr == crt_pkg::OFS_STATUS && !reset_busy_flag |=> reg_rdata == 16'h0000)
    else $error("status not zero when ready");
  status_busy_a: assert property (reg_rd && reg_addr == crt_pkg::OFS_STATUS && reset_busy_flag ##1 reset_busy_flag
    |-> reg_rdata[crt_pkg::STAT_BUSY_BIT])
    else $error("status busy bit low during clear");
  mem_clear_read_a: assert property (reg_rd && reg_addr >= crt_pkg::MEM_LO && reset_busy_flag |=> reg_rdata == 16'h0000)
    else $error("memory word not zero during clear");
endmodule : crt_seq_sva
`default_nettype wire

/* verification/crt_host.sv */
/* Host model on the register port: reset, clock mode and one-cycle strobes.
   Assumes the sequencer answers a read in the cycle after the strobe. */
`timescale 1ns/1ps
`default_nettype none
module crt_host (
  input wire logic clk_sys,
  output logic reset_n,
  output logic clock_select,
  output logic [8:0] reg_addr,
  output logic [15:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic reset_busy_flag
);
  int since_rel = 0;
  initial begin
    reset_n = 1'b0;
    clock_select = 1'b0;
    reg_addr = 9'h000;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  always @(posedge clk_sys) since_rel <= reset_n ? since_rel + 1 : 0;
  ////////////////////////////////////////////////////////////////////////////////
  // The clock is never gated, so it runs through the whole reset
  task automatic do_reset(input logic cs, input int len);
    @(posedge clk_sys);
    reset_n <= 1'b0;
    clock_select <= cs;
    repeat (len) @(posedge clk_sys);
    reset_n <= 1'b1;
  endtask : do_reset
  // No access before busy clears; the count is the busy length after release
  task automatic wait_ready(output int n);
    int i;
    i = 0;
    while (reset_busy_flag !== 1'b0 && i < 1000) begin
      @(posedge clk_sys);
      i++;
    end
    n = since_rel;
  endtask : wait_ready
  task automatic wr(input logic [8:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask : wr
  task automatic rd(input logic [8:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(posedge clk_sys);
    d = reg_rdata;
  endtask : rd
endmodule : crt_host
`default_nettype wire

/* verification/test_center_reset_init_and_cycle_timing.sv */
/* Bench of the reset sequencer: a table of register accesses after a short clear,
   then long clear, refused writes and a reset in mid-clear.
   Assumes the host model drives every sequencer input except clk_sys. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin err_total++; \
  $display("wrong value %s expected %h seen %h", nm, exp, got); end end
module test_center_reset_init_and_cycle_timing;
  typedef struct {logic wr; logic [8:0] a; logic [15:0] d;} crt_row_t;
  logic clk_sys, reset_n, clock_select, reg_wr, reg_rd, reset_busy_flag;
  logic [8:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, got;
  int err_total = 0, cmp_count = 0, cyc = 0, n, k, ct, st, jt, ex, tot;
  crt_row_t rows[$];
  logic [8:0] zero_a[10] = '{crt_pkg::OFS_COMMAND, crt_pkg::OFS_STATUS, crt_pkg::OFS_IRQ_STATUS,
    crt_pkg::OFS_IO_BUFFER, crt_pkg::OFS_TIME_CFG, crt_pkg::OFS_DEV_COUNT, crt_pkg::MEM_LO,
    9'h100, crt_pkg::MEM_HI, 9'h013};
  crt_host host (.clk_sys(clk_sys), .reset_n(reset_n), .clock_select(clock_select), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reset_busy_flag(reset_busy_flag));
  crt_seq dut (.clk_sys(clk_sys), .reset_n(reset_n), .clock_select(clock_select), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reset_busy_flag(reset_busy_flag));
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      err_total++;
      tally_and_finish();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  task automatic add(input logic w, input logic [8:0] a, input logic [15:0] d);
    rows.push_back('{w, a, d});
  endtask : add
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    host.do_reset(1'b0, 16);
    host.wait_ready(n);
    `CHK("short clear", 1'b1, n >= 270)
    foreach (zero_a[i]) add(1'b0, zero_a[i], 16'h0000);
    add(1'b1, crt_pkg::OFS_IO_BUFFER, 16'hBEEF);
    add(1'b0, crt_pkg::OFS_IO_BUFFER, 16'hBEEF);
    add(1'b1, crt_pkg::OFS_REVISION, 16'hFFFF);
    add(1'b0, crt_pkg::OFS_REVISION, crt_pkg::REVISION_CODE);
    add(1'b1, 9'h013, 16'hFFFF);
    add(1'b0, 9'h013, 16'h0000);
    add(1'b1, crt_pkg::MEM_HI, 16'hABCD);
    add(1'b0, crt_pkg::MEM_HI, 16'hABCD);
    add(1'b1, crt_pkg::OFS_TX_DATA, 16'h1357);
    add(1'b0, crt_pkg::OFS_FIFO_LEVEL, 16'h0001);
    add(1'b0, crt_pkg::OFS_RX_DATA, 16'h1357);
    add(1'b0, crt_pkg::OFS_FIFO_LEVEL, 16'h0000);
    add(1'b1, crt_pkg::OFS_DEV_COUNT, 16'h007F);
    add(1'b1, crt_pkg::OFS_SEND_BYTES, 16'h0002);
    add(1'b1, crt_pkg::OFS_REPLY_BYTES, 16'h0006);
    add(1'b1, crt_pkg::OFS_EXCH_COUNT, 16'h0004);
    // Times in 50 ns units: 7.7 us = 154, 7.4 us = 148, one byte = 12
    for (int c = 0; c < 4; c++) begin
      for (int r = 0; r < 2; r++) begin
        k = 1 << c;
        ct = 154 * k;
        st = (2 * 12 + 65) * k;
        jt = r ? (6 * 12 + 113) * k : 101 * k;
        ex = st + jt + 148;
        tot = (ct + 148) * 127 + ex * 4;
        add(1'b1, crt_pkg::OFS_TIME_CFG, 16'(c + 4 * r));
        add(1'b0, crt_pkg::OFS_CT_TIME, 16'(ct));
        add(1'b0, crt_pkg::OFS_SEND_TIME, 16'(st));
        add(1'b0, crt_pkg::OFS_REPLY_TIME, 16'(jt));
        add(1'b0, crt_pkg::OFS_EXCH_TIME, 16'(ex));
        add(1'b0, crt_pkg::OFS_TOTAL_LO, 16'(tot));
        add(1'b0, crt_pkg::OFS_TOTAL_HI, 16'(tot >> 16));
      end
    end
    // Results settle two cycles after a configuration write
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        host.wr(rows[i].a, rows[i].d);
        repeat (2) @(posedge clk_sys);
      end else begin
        host.rd(rows[i].a, got);
        `CHK("table read", rows[i].d, got)
      end
    end
    $display("test table done");
    host.wr(crt_pkg::OFS_COMMAND, 16'h1234);
    host.do_reset(1'b1, 10);
    host.rd(crt_pkg::OFS_STATUS, got);
    `CHK("status in clear", 1'b1, got[crt_pkg::STAT_BUSY_BIT])
    host.rd(crt_pkg::MEM_HI, got);
    `CHK("memory in clear", 16'h0000, got)
    host.wr(crt_pkg::OFS_COMMAND, 16'hFFFF);
    host.wait_ready(n);
    `CHK("long clear", 1'b1, n >= 540)
    foreach (zero_a[i]) begin
      host.rd(zero_a[i], got);
      `CHK("after long clear", 16'h0000, got)
    end
    $display("test long clear done");
    host.wr(9'h100, 16'h5555);
    host.do_reset(1'b0, 10);
    repeat (100) @(posedge clk_sys);
    host.do_reset(1'b0, 10);
    host.wait_ready(n);
    `CHK("restarted clear", 1'b1, n >= 270)
    host.rd(9'h100, got);
    `CHK("memory after restart", 16'h0000, got)
    $display("test mid clear reset done");
    tally_and_finish();
  end
endmodule : test_center_reset_init_and_cycle_timing
bind crt_seq crt_seq_sva chk (.clk_sys(clk_sys), .reset_n(reset_n), .clock_select(clock_select),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .reset_busy_flag(reset_busy_flag));
`default_nettype wire
